// ---- core/rhi_core.sv ----
// Serial target port and command decoder of a single-channel rheostat.
// Assumes an external pull-up on the data line, a free-running link clock
// well above eight times the serial bit rate, and synchronous reset release.
// ADDR_SEL_I code 3 cannot come from a three-level pin; it decodes as open.
`timescale 1ns/1ps
`include "rhi_params.svh"

module rhi_core
#(
	parameter int STORE_CYCLES = `RHI_STORE_CYC
)
(
	input  wire logic                  CLOCK_I,
	input  wire logic                  RST_I,
	input  wire logic                  NVM_RST_I,
	input  wire logic                  LINK_CLK_I,
	input  wire logic                  SCL_I,
	input  wire logic                  SDA_I,
	output logic                       SDA_O,
	output logic                       SDA_OE_N_O,
	input  wire rhi_pkg::rhi_addr_sel_t ADDR_SEL_I,
	output rhi_pkg::rhi_wiper_t        WIPER_O,
	output logic                       BUSY_O
);
	import rhi_pkg::*;

	// Fuse memory survives RST_I; only NVM_RST_I (a fresh part) clears its fill count otp_last, not the entries.
	logic [9:0]  otp_mem [1:50];
	logic [5:0]  otp_last;
	logic        otp_we;
	logic [9:0]  restore_val;

	rhi_link_t   l, next_l;
	rhi_sys_t    s, next_s;

	function automatic logic [6:0] own_addr(input logic [1:0] sel);
		unique case (sel)
			ASEL_LOW:  own_addr = {`RHI_ADDR_HI, 2'h3};
			ASEL_HIGH: own_addr = {`RHI_ADDR_HI, 2'h0};
			ASEL_OPEN: own_addr = {`RHI_ADDR_HI, 2'h2};
			// The unused code falls back to open rather than to no address.
			default:   own_addr = {`RHI_ADDR_HI, 2'h2};
		endcase
	endfunction

	function automatic logic [15:0] pack_word(input logic [9:0] v);
		pack_word = {6'h00, v};
	endfunction

	// A blank array leaves the wiper at midscale until the first store.
	assign restore_val = (otp_last == 6'h00) ? `RHI_WIPER_MID
		: otp_mem[otp_last];

	// Link domain: bit-level target on the fast link clock.
	always_comb
	begin
		logic scl_r, scl_f, start, stop;
		scl_r = 1'b0;
		scl_f = 1'b0;
		start = 1'b0;
		stop  = 1'b0;
		next_l      = l;
		// Oversampling far above the bit rate serves both bus speeds alike.
		next_l.scl1 = SCL_I;
		next_l.scl2 = l.scl1;
		next_l.scl3 = l.scl2;
		next_l.sda1 = SDA_I;
		next_l.sda2 = l.sda1;
		next_l.sda3 = l.sda2;
		next_l.adr1 = ADDR_SEL_I;
		next_l.adr2 = l.adr1;
		next_l.bsy1 = s.busy;
		next_l.bsy2 = l.bsy1;
		next_l.rtg1 = s.rd_tog;
		next_l.rtg2 = l.rtg1;
		next_l.rtg3 = l.rtg2;
		// Read word is stable long before its toggle lands here.
		if (l.rtg3 != l.rtg2)
			next_l.rd_word = s.rd_word;
		scl_r = l.scl2 & ~l.scl3;
		scl_f = ~l.scl2 & l.scl3;
		start = l.scl2 & l.scl3 & l.sda3 & ~l.sda2;
		stop  = l.scl2 & l.scl3 & ~l.sda3 & l.sda2;
		if (start)
		begin
			next_l.st       = L_ADDR;
			next_l.cnt      = 4'h0;
			next_l.hi_done  = 1'b0;
			next_l.sda_oe_n = 1'b1;
		end
		else if (stop)
		begin
			next_l.st       = L_IDLE;
			next_l.sda_oe_n = 1'b1;
		end
		else
		begin
			unique case (l.st)
				L_IDLE:
				begin
					next_l.sda_oe_n = 1'b1;
				end
				L_ADDR, L_WR:
				begin
					// Sampling on the rising edge keeps data honest while high.
					if (scl_r)
					begin
						next_l.sh  = {l.sh[6:0], l.sda2};
						next_l.cnt = l.cnt + 4'h1;
					end
					if (scl_f && l.cnt == 4'h8 && l.st == L_ADDR)
					begin
						// General call and 10-bit prefixes never match here.
						if (l.sh[7:1] == own_addr(l.adr2) && !l.bsy2)
						begin
							next_l.st       = L_AACK;
							next_l.rw       = l.sh[0];
							next_l.sda_oe_n = 1'b0;
						end
						else
							next_l.st = L_IDLE;
					end
					else if (scl_f && l.cnt == 4'h8)
					begin
						next_l.st       = L_WACK;
						next_l.sda_oe_n = 1'b0;
						next_l.hi_done  = ~l.hi_done;
						if (!l.hi_done)
							next_l.cmd[15:8] = l.sh;
						else
						begin
							next_l.cmd[7:0] = l.sh;
							next_l.req_tog  = ~l.req_tog;
						end
					end
				end
				L_AACK:
				begin
					if (scl_f)
					begin
						next_l.cnt = 4'h0;
						if (l.rw)
						begin
							next_l.st       = L_RD;
							next_l.tx       = l.rd_word[15:8];
							next_l.sda_oe_n = l.rd_word[15];
						end
						else
						begin
							next_l.st       = L_WR;
							next_l.sda_oe_n = 1'b1;
						end
					end
				end
				L_WACK:
				begin
					if (scl_f)
					begin
						next_l.st       = L_WR;
						next_l.cnt      = 4'h0;
						next_l.sda_oe_n = 1'b1;
					end
				end
				L_RD:
				begin
					if (scl_r)
						next_l.cnt = l.cnt + 4'h1;
					if (scl_f)
					begin
						if (l.cnt == 4'h8)
						begin
							next_l.st       = L_RACK;
							next_l.sda_oe_n = 1'b1;
						end
						else
						begin
							next_l.tx       = {l.tx[6:0], 1'b1};
							next_l.sda_oe_n = l.tx[6];
						end
					end
				end
				L_RACK:
				begin
					if (scl_r)
						next_l.ack = ~l.sda2;
					if (scl_f)
					begin
						next_l.cnt = 4'h0;
						// No second byte after a refused first one.
						if (l.ack && !l.hi_done)
						begin
							next_l.st       = L_RD;
							next_l.hi_done  = 1'b1;
							next_l.tx       = l.rd_word[7:0];
							next_l.sda_oe_n = l.rd_word[7];
						end
						else
							next_l.st = L_IDLE;
					end
				end
				default:
				begin
					next_l.st       = L_IDLE;
					next_l.sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge LINK_CLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			l          <= '0;
			l.scl1     <= 1'b1;
			l.scl2     <= 1'b1;
			l.scl3     <= 1'b1;
			l.sda1     <= 1'b1;
			l.sda2     <= 1'b1;
			l.sda3     <= 1'b1;
			l.st       <= L_IDLE;
			l.sda_oe_n <= 1'b1;
		end
		else
			l <= next_l;
	end

	// Core domain: command decoder, wiper, control flags and store lock.
	// The command word is read straight from the link flops: it settled at
	// the link edge that flipped the toggle, two flops earlier, and the next
	// frame cannot overwrite it for many microseconds.
	always_comb
	begin
		logic [9:0] data;
		rhi_cmd_t   code;
		data   = l.cmd[9:0];
		code   = rhi_cmd_t'(l.cmd[`RHI_CMD_MSB:`RHI_CMD_LSB]);
		otp_we = 1'b0;
		next_s      = s;
		next_s.req1 = l.req_tog;
		next_s.req2 = s.req1;
		next_s.req3 = s.req2;
		next_s.boot = 1'b0;
		if (s.boot)
			next_s.out.wiper = restore_val;
		// The lock length is a parameter so that a bench may shorten it; a
		// lock shorter than the real fuse time would let a poll end too soon.
		if (s.busy)
		begin
			next_s.lock_cnt = s.lock_cnt - 22'h1;
			if (s.lock_cnt == 22'h1)
				next_s.busy = 1'b0;
		end
		if (s.req3 != s.req2 && !s.busy)
		begin
			unique case (code)
				CMD_WR_WIPER:
					if (s.ctrl[`RHI_CTRL_UNLOCK])
						next_s.out.wiper = data & `RHI_WIPER_MASK;
				CMD_RD_WIPER:
				begin
					next_s.rd_word = pack_word(s.out.wiper);
					next_s.rd_tog  = ~s.rd_tog;
				end
				CMD_STORE:
				begin
					if (s.ctrl[`RHI_CTRL_PROG] && otp_last < `RHI_OTP_DEPTH)
					begin
						otp_we = 1'b1;
						next_s.ctrl[`RHI_CTRL_OK] = 1'b1;
						next_s.busy     = 1'b1;
						next_s.lock_cnt = STORE_CYCLES[21:0];
					end
					else
						next_s.ctrl[`RHI_CTRL_OK] = 1'b0;
				end
				CMD_SW_RESET:
					next_s.out.wiper = restore_val;
				CMD_RD_OTP:
				begin
					if (data[`RHI_SEL_MSB:0] != 6'h00
						&& data[`RHI_SEL_MSB:0] <= `RHI_OTP_DEPTH)
						next_s.rd_word = pack_word(
							otp_mem[data[`RHI_SEL_MSB:0]]);
					else
						next_s.rd_word = 16'h0000;
					next_s.rd_tog = ~s.rd_tog;
				end
				CMD_RD_LAST:
				begin
					next_s.rd_word = pack_word({4'h0, otp_last});
					next_s.rd_tog  = ~s.rd_tog;
				end
				CMD_WR_CTRL:
					next_s.ctrl[2:0] = data[2:0];
				CMD_RD_CTRL:
				begin
					next_s.rd_word = pack_word({6'h00, s.ctrl});
					next_s.rd_tog  = ~s.rd_tog;
				end
				CMD_SHUTDOWN:
					next_s.out.shutdown = data[0];
				default:
					next_s.rd_tog = s.rd_tog;
			endcase
		end
		next_s.out.tol_cal_dis = next_s.ctrl[`RHI_CTRL_TOLDIS];
	end

	always_ff @(posedge CLOCK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			s           <= '0;
			s.boot      <= 1'b1;
			s.out.wiper <= `RHI_WIPER_MID;
			s.ctrl      <= `RHI_CTRL_RESET;
		end
		else
			s <= next_s;
	end

	// Each store takes the next free entry; entries count from one.
	always_ff @(posedge CLOCK_I or posedge NVM_RST_I)
	begin
		if (NVM_RST_I)
			otp_last <= 6'h00;
		else if (otp_we)
			otp_last <= otp_last + 6'h01;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (otp_we)
			otp_mem[otp_last + 6'h01] <= s.out.wiper;
	end

	// Open drain: the pin only ever pulls low, so its level is constant and
	// the enable alone carries acknowledge and read data.
	assign SDA_O      = 1'b0;
	assign SDA_OE_N_O = l.sda_oe_n;
	assign WIPER_O    = s.out;
	assign BUSY_O     = s.busy;

endmodule

// ---- core/rhi_params.svh ----
// Constants for the rheostat serial command port: offsets, fields, timing.
// Assumes a 10 MHz core clock; included by the core only.
`ifndef RHI_PARAMS_SVH
`define RHI_PARAMS_SVH

`define RHI_ADDR_HI      5'h0B
`define RHI_WIPER_MID    10'h200
`define RHI_WIPER_MASK   10'h3FF
`define RHI_OTP_DEPTH    6'h32
`define RHI_CTRL_RESET   4'h0
`define RHI_CTRL_WMASK   4'h7
`define RHI_CMD_MSB      13
`define RHI_CMD_LSB      10
`define RHI_SEL_MSB      5
`define RHI_CTRL_PROG    0
`define RHI_CTRL_UNLOCK  1
`define RHI_CTRL_TOLDIS  2
`define RHI_CTRL_OK      3
`define RHI_CLK_HZ       10000000
`define RHI_STORE_MS     350
`define RHI_STORE_CYC    (`RHI_STORE_MS * (`RHI_CLK_HZ / 1000))

`endif

// ---- core/rhi_pkg.sv ----
// Types shared by the rheostat serial command port.
// Constants live in rhi_params.svh; this package holds types only.
package rhi_pkg;

	typedef enum logic [3:0]
	{
		CMD_NOP      = 4'h0,
		CMD_WR_WIPER = 4'h1,
		CMD_RD_WIPER = 4'h2,
		CMD_STORE    = 4'h3,
		CMD_SW_RESET = 4'h4,
		CMD_RD_OTP   = 4'h5,
		CMD_RD_LAST  = 4'h6,
		CMD_WR_CTRL  = 4'h7,
		CMD_RD_CTRL  = 4'h8,
		CMD_SHUTDOWN = 4'h9
	} rhi_cmd_t;

	typedef enum logic [1:0]
	{
		ASEL_LOW  = 2'h0,
		ASEL_HIGH = 2'h1,
		ASEL_OPEN = 2'h2
	} rhi_addr_sel_t;

	typedef enum logic [2:0]
	{
		L_IDLE = 3'h0,
		L_ADDR = 3'h1,
		L_AACK = 3'h2,
		L_WR   = 3'h3,
		L_WACK = 3'h4,
		L_RD   = 3'h5,
		L_RACK = 3'h6
	} rhi_lstate_t;

	typedef struct packed
	{
		logic       shutdown;
		logic       tol_cal_dis;
		logic [9:0] wiper;
	} rhi_wiper_t;

	typedef struct packed
	{
		logic        scl1, scl2, scl3;
		logic        sda1, sda2, sda3;
		logic [1:0]  adr1, adr2;
		logic        bsy1, bsy2;
		logic        rtg1, rtg2, rtg3;
		rhi_lstate_t st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  tx;
		logic        rw;
		logic        hi_done;
		logic        ack;
		logic        sda_oe_n;
		logic [15:0] cmd;
		logic        req_tog;
		logic [15:0] rd_word;
	} rhi_link_t;

	typedef struct packed
	{
		rhi_wiper_t  out;
		logic [3:0]  ctrl;
		logic        boot;
		logic        busy;
		logic [21:0] lock_cnt;
		logic        req1, req2, req3;
		logic        rd_tog;
		logic [15:0] rd_word;
	} rhi_sys_t;

endpackage

// ---- tb/rhi_core_bench.sv ----
// Self-checking bench of the rheostat serial command port.
// Assumes the package, the core and the controller model compile first.
`timescale 1ns/1ps
module rhi_core_bench;
	import rhi_pkg::*;
	localparam int STORE = 2000;
	logic          clock = 1'b0;
	logic          link_clk = 1'b0;
	logic          rst = 1'b1;
	logic          nvm_rst = 1'b1;
	logic          host_scl;
	logic          host_sda;
	logic          oe_n;
	logic          sda_o;
	logic          busy;
	rhi_addr_sel_t sel = ASEL_LOW;
	rhi_wiper_t    wiper;
	logic [6:0]    addr = 7'h2F;
	logic [6:0]    adr_tab [3] = '{7'h2F, 7'h2C, 7'h2E};
	int            failures = 0;
	int            n_checks = 0;
	wire logic     sda_line = host_sda & (oe_n | sda_o);
	initial
		forever #50 clock = ~clock;
	initial
	begin
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	rhi_core #(.STORE_CYCLES(STORE)) dut_u
	(
		.CLOCK_I(clock),
		.RST_I(rst),
		.NVM_RST_I(nvm_rst),
		.LINK_CLK_I(link_clk),
		.SCL_I(host_scl),
		.SDA_I(sda_line),
		.SDA_O(sda_o),
		.SDA_OE_N_O(oe_n),
		.ADDR_SEL_I(sel),
		.WIPER_O(wiper),
		.BUSY_O(busy)
	);
	rhi_host_model host_u
	(
		.CLOCK_I(clock),
		.SDA_I(sda_line),
		.SCL_O(host_scl),
		.SDA_O(host_sda)
	);
	task automatic chk_val(input string nm, input logic [15:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmd(input logic [3:0] c, input logic [9:0] d);
		logic ok;
		host_u.wr(addr, {2'b00, c, d}, ok);
		chk_val("write ack", 16'h1, {15'h0, ok});
		repeat (10) @(negedge clock);
	endtask
	task automatic rdback(input logic [3:0] c, input logic [9:0] d, e);
		logic        ok;
		logic [15:0] w;
		cmd(c, d);
		host_u.rd(addr, w, ok);
		chk_val("read ack", 16'h1, {15'h0, ok});
		chk_val("read word", {6'h00, e}, w);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		logic ok;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		nvm_rst = 1'b0;
		repeat (4) @(negedge clock);
		chk_val("wiper", 16'h0200, {6'h0, wiper.wiper});
		rdback(4'h8, 10'h000, 10'h000);
		rdback(4'h2, 10'h3FF, 10'h200);
		cmd(4'h1, 10'h155);
		chk_val("frozen", 16'h0200, {6'h0, wiper.wiper});
		$display("test defaults done");
		cmd(4'h7, 10'h3FE);
		rdback(4'h8, 10'h000, 10'h006);
		chk_val("tol", 16'h1, {15'h0, wiper.tol_cal_dis});
		cmd(4'h1, 10'h155);
		rdback(4'h2, 10'h000, 10'h155);
		cmd(4'h0, 10'h3FF);
		chk_val("nop", 16'h0155, {6'h0, wiper.wiper});
		$display("test wiper done");
		cmd(4'h3, 10'h000);
		chk_val("idle", 16'h0, {15'h0, busy});
		rdback(4'h8, 10'h000, 10'h006);
		cmd(4'h7, 10'h003);
		cmd(4'h3, 10'h000);
		chk_val("busy", 16'h1, {15'h0, busy});
		host_u.wr(addr, 16'h0000, ok);
		chk_val("locked ack", 16'h0, {15'h0, ok});
		for (int i = 0; i < 40 && !ok; i++)
			host_u.wr(addr, 16'h0000, ok);
		chk_val("poll ack", 16'h1, {15'h0, ok});
		if (!ok)
			tally_and_finish();
		rdback(4'h8, 10'h000, 10'h00B);
		rdback(4'h6, 10'h000, 10'h001);
		rdback(4'h5, 10'h3C1, 10'h155);
		rdback(4'h5, 10'h3C0, 10'h000);
		rdback(4'h5, 10'h033, 10'h000);
		$display("test store done");
		cmd(4'h1, 10'h0AA);
		cmd(4'h4, 10'h000);
		chk_val("swreset", 16'h0155, {6'h0, wiper.wiper});
		cmd(4'hA, 10'h0AA);
		chk_val("ignored", 16'h0155, {6'h0, wiper.wiper});
		cmd(4'h9, 10'h3FF);
		chk_val("shutdown", 16'h1, {15'h0, wiper.shutdown});
		cmd(4'h9, 10'h3FE);
		chk_val("normal", 16'h0, {15'h0, wiper.shutdown});
		host_u.quarter = 25;
		rdback(4'h2, 10'h000, 10'h155);
		host_u.quarter = 7;
		$display("test modes done");
		for (int k = 0; k < 3; k++)
		begin
			sel = rhi_addr_sel_t'(k);
			addr = adr_tab[k];
			repeat (4) @(negedge clock);
			cmd(4'h0, 10'h000);
			host_u.wr(adr_tab[(k + 1) % 3], 16'h0000, ok);
			chk_val("other addr", 16'h0, {15'h0, ok});
		end
		host_u.wr(7'h00, 16'h0000, ok);
		chk_val("general call", 16'h0, {15'h0, ok});
		host_u.wr(7'h78, 16'h0000, ok);
		chk_val("ten bit", 16'h0, {15'h0, ok});
		$display("test address done");
		rst = 1'b1;
		repeat (10) @(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		chk_val("restore", 16'h0155, {6'h0, wiper.wiper});
		$display("test power-up done");
		tally_and_finish();
	end
endmodule

// ---- tb/rhi_core_monitor.sv ----
// Port checks of the rheostat serial command port.
// Assumes the bind below hands on the lock length of the core.
`timescale 1ns/1ps
module rhi_core_monitor
#(
	parameter int STORE_CYCLES = 200
)
(
	input  wire logic               CLOCK_I,
	input  wire logic               RST_I,
	input  wire logic               LINK_CLK_I,
	input  wire logic               SCL_I,
	input  wire logic               SDA_O,
	input  wire logic               SDA_OE_N_O,
	input  wire rhi_pkg::rhi_wiper_t WIPER_O,
	input  wire logic               BUSY_O
);
	import rhi_pkg::*;
	logic [31:0] busy_len;
	always_ff @(posedge CLOCK_I or posedge RST_I)
		if (RST_I)
			busy_len <= 32'h0;
		else
			busy_len <= BUSY_O ? busy_len + 32'h1 : 32'h0;
	chk_lock_length: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		$fell(BUSY_O) |-> busy_len + 32'h1 >= STORE_CYCLES
			&& busy_len <= STORE_CYCLES + 1)
		else $error("store lock length wrong");
	chk_lock_bound: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		busy_len <= STORE_CYCLES + 1)
		else $error("store lock too long");
	chk_wiper_frozen: assert property (
		@(posedge CLOCK_I) disable iff (RST_I)
		$changed(WIPER_O) |-> !$past(BUSY_O))
		else $error("wiper changed while locked");
	chk_drive_low: assert property (
		@(posedge LINK_CLK_I) disable iff (RST_I)
		SDA_O == 1'b0)
		else $error("data line driven high");
	chk_no_ack_lock: assert property (
		@(posedge LINK_CLK_I) disable iff (RST_I)
		$fell(SDA_OE_N_O) |-> !BUSY_O)
		else $error("line pulled low while locked");
	chk_hold_high_scl: assert property (
		@(posedge LINK_CLK_I) disable iff (RST_I)
		SCL_I && $past(SCL_I) |-> $stable(SDA_OE_N_O))
		else $error("data changed while clock high");
	chk_pull_clock_low: assert property (
		@(posedge LINK_CLK_I) disable iff (RST_I)
		$fell(SDA_OE_N_O) |-> !SCL_I)
		else $error("line pulled while clock high");
	chk_ack_width: assert property (
		@(posedge LINK_CLK_I) disable iff (RST_I)
		$fell(SDA_OE_N_O) |=> !SDA_OE_N_O [*8])
		else $error("low drive too short");
	chk_release_reset: assert property (
		@(posedge LINK_CLK_I) disable iff (RST_I)
		$fell(RST_I) |-> SDA_OE_N_O)
		else $error("line driven after reset");
	cover property (@(posedge CLOCK_I) $fell(BUSY_O));
	cover property (@(posedge LINK_CLK_I) $fell(SDA_OE_N_O));
	cover property (@(posedge CLOCK_I) $rose(WIPER_O.shutdown));
endmodule

bind rhi_core rhi_core_monitor #(.STORE_CYCLES(STORE_CYCLES)) mon_u
(
	.CLOCK_I(CLOCK_I),
	.RST_I(RST_I),
	.LINK_CLK_I(LINK_CLK_I),
	.SCL_I(SCL_I),
	.SDA_O(SDA_O),
	.SDA_OE_N_O(SDA_OE_N_O),
	.WIPER_O(WIPER_O),
	.BUSY_O(BUSY_O)
);

// ---- tb/rhi_host_model.sv ----
// Bus controller model that drives the serial clock and data lines.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module rhi_host_model
(
	input  wire logic CLOCK_I,
	input  wire logic SDA_I,
	output logic      SCL_O,
	output logic      SDA_O
);
	// Seven core cycles a quarter bit keeps the rate below 400 kHz.
	int quarter = 7;
	initial
	begin
		SCL_O = 1'b1;
		SDA_O = 1'b1;
	end
	task automatic q();
		repeat (quarter) @(negedge CLOCK_I);
	endtask
	task automatic start();
		SDA_O = 1'b1;
		SCL_O = 1'b1;
		q();
		SDA_O = 1'b0;
		q();
		SCL_O = 1'b0;
	endtask
	task automatic xfer(input logic b, output logic r);
		q();
		SDA_O = b;
		q();
		SCL_O = 1'b1;
		q();
		r = SDA_I;
		q();
		SCL_O = 1'b0;
	endtask
	task automatic octet(input logic [7:0] d, input logic a,
		output logic [7:0] r, output logic ak);
		for (int i = 7; i >= 0; i--)
			xfer(d[i], r[i]);
		xfer(a, ak);
	endtask
	task automatic stop();
		q();
		SDA_O = 1'b0;
		q();
		SCL_O = 1'b1;
		q();
		SDA_O = 1'b1;
		q();
	endtask
	// An unanswered address ends the frame at once, so a write also polls.
	task automatic wr(input logic [6:0] a, input logic [15:0] w,
		output logic ok);
		logic [7:0] r;
		logic       ak;
		start();
		octet({a, 1'b0}, 1'b1, r, ak);
		ok = !ak;
		if (ok)
		begin
			octet(w[15:8], 1'b1, r, ak);
			ok = ok & !ak;
			octet(w[7:0], 1'b1, r, ak);
			ok = ok & !ak;
		end
		stop();
	endtask
	task automatic rd(input logic [6:0] a, output logic [15:0] w,
		output logic ok);
		logic ak;
		start();
		octet({a, 1'b1}, 1'b1, w[15:8], ak);
		ok = !ak;
		if (ok)
		begin
			octet(8'hFF, 1'b0, w[15:8], ak);
			octet(8'hFF, 1'b1, w[7:0], ak);
		end
		stop();
	endtask
endmodule
